// ### hw/sac_defs.svh
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

// register map, index on the 2-bit register address
`define SAC_ADDR_W        2
`define SAC_DATA_W        8
`define SAC_CTRL_OFF      2'h0
`define SAC_STATUS_OFF    2'h1
`define SAC_RESULT_OFF    2'h2

// control fields and reset values
`define SAC_CTRL_TWIN_BIT 0
`define SAC_CTRL_RST      1'h1

// status fields
`define SAC_ST_BUSY_BIT   0
`define SAC_ST_MODE_BIT   1
`define SAC_ST_PICK_BIT   2
`define SAC_ST_TWIN_BIT   3
`define SAC_ST_DONE_BIT   4

// serial sequence counts
`define SAC_RES_W         8
`define SAC_MSB_IDX       3'h7
`define SAC_LSB_FIRST     3'h1
`define SAC_LSB_LAST      3'h7
`define SAC_ADDR_LAST     1'h1
`define SAC_MSB_COUNT     4'h8
`define SAC_TRIAL_FIRST   8'h80

`endif

// ### hw/sac_pkg.sv
`default_nettype none

package sac_pkg;

    typedef enum logic [5:0] {
        st_idle   = 6'b000001,
        st_addr   = 6'b000010,
        st_settle = 6'b000100,
        st_msb    = 6'b001000,
        st_lsb    = 6'b010000,
        st_done   = 6'b100000
    } sac_state_type;

    typedef logic [7:0] sac_byte_type;

endpackage

`default_nettype wire

// ### hw/sac_edge_detect.sv
`timescale 1ns/100ps
`default_nettype none

module sac_edge_detect (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic level_i,
    output logic      rise_o,
    output logic      fall_o
);

    logic level_q;

    // level is synchronous to sys_clk, so no synchroniser stage needed
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_i;
        end
    end

    assign rise_o = level_i & ~level_q;
    assign fall_o = ~level_i & level_q;

endmodule

`default_nettype wire

// ### hw/sac_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "sac_defs.svh"

module sac_regs (
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_i,
    input  wire logic [`SAC_ADDR_W-1:0]   reg_addr_i,
    input  wire logic [`SAC_DATA_W-1:0]   reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    input  wire sac_pkg::sac_byte_type    status_i,
    input  wire sac_pkg::sac_byte_type    result_i,
    output logic                          twin_o,
    output sac_pkg::sac_byte_type         reg_rdata_o
);
    import sac_pkg::*;

    logic         twin;
    sac_byte_type next_rdata;
    wire          hit_ctrl   = (reg_addr_i == `SAC_CTRL_OFF);
    wire          hit_status = (reg_addr_i == `SAC_STATUS_OFF);
    wire          hit_result = (reg_addr_i == `SAC_RESULT_OFF);

    // unmapped offsets read as zero, writes to them are dropped
    always_comb begin
        if (!reg_rd_i) begin
            next_rdata = 8'h00;
        end else if (hit_ctrl) begin
            next_rdata = {7'h00, twin};
        end else if (hit_status) begin
            next_rdata = status_i;
        end else if (hit_result) begin
            next_rdata = result_i;
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            twin        <= `SAC_CTRL_RST;
            reg_rdata_o <= 8'h00;
        end else begin
            if (reg_wr_i && hit_ctrl) begin
                twin <= reg_wdata_i[`SAC_CTRL_TWIN_BIT];
            end
            reg_rdata_o <= next_rdata;
        end
    end

    assign twin_o = twin;

endmodule

`default_nettype wire

// ### hw/sac_top.sv
// Function
// - select low enables all converter logic and opens a conversion
// - one settling period after start, output leaves high-z driving low
// - each decided result bit appears on output as resolved, msb first
// - conversion ends after eight periods, one result bit each
// - select high clears the sequencer registers and floats the output; result_hold, the done flag and the control register are kept
// - each serial clock rise after the start bit while addressing samples the data input into the address register
// - low input levels before start are ignored; first high is start bit
// - twin variant: two-bit word follows start, mode bit then channel pick
// - start bit reaching start position selects channel and starts converting
// - data input ignored from conversion start until select rises
// - twin variant repeats the result lsb first after the msb stream
// - input sampled only while addressing, output still high-z
// - differential mode: channel pick chooses which channel is positive
// - single-ended mode: channel pick chooses channel, measured against ground
// - single-channel variant skips addressing and converts right after start
// - positive input below negative gives an all-zero result
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sac_defs.svh"

module sac_top (
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     select_n_i,
    input  wire logic                     serial_clk_i,
    input  wire logic                     serial_address_in_i,
    input  wire logic                     comparator_i,
    output logic                          data_o,
    output logic                          data_oe_o,
    output sac_pkg::sac_byte_type         approximation_register_o,
    output logic                          channel_one_positive_o,
    output logic                          single_ended_o,
    output logic                          converting_o,
    input  wire logic [`SAC_ADDR_W-1:0]   reg_addr_i,
    input  wire logic [`SAC_DATA_W-1:0]   reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output sac_pkg::sac_byte_type         reg_rdata_o
);
    import sac_pkg::*;

    sac_state_type state;
    sac_byte_type  approximation_register;
    sac_byte_type  result_hold;
    logic [2:0]    bit_idx;
    logic [1:0]    addr_sr;
    logic          addr_cnt;
    logic          input_mode_select;
    logic          channel_pick;
    logic          twin_latched;
    logic          data_bit;
    logic          data_oe;
    logic          done_flag;
    logic          twin_cfg;
    logic          sclk_rise;
    logic          sclk_fall;
    logic [3:0]    msb_falls;
    sac_byte_type  status_word;

    // select low is the master enable; high forces the sequencer back but keeps result, done flag and control register
    wire active      = ~select_n_i;
    wire rise_act    = active & sclk_rise;
    wire fall_act    = active & sclk_fall;
    // input is looked at only before conversion starts
    wire addressing  = (state == st_idle) | (state == st_addr);
    wire start_seen  = rise_act & (state == st_idle) & serial_address_in_i;
    wire addr_done   = rise_act & (state == st_addr) & (addr_cnt == `SAC_ADDR_LAST);
    wire msb_last    = (bit_idx == 3'h0);
    wire lsb_last    = (bit_idx == `SAC_LSB_LAST);
    wire [2:0] idx_dn = bit_idx - 3'h1;
    wire [2:0] idx_up = bit_idx + 3'h1;
    // comparator stays low when positive input is below negative, so every
    // trial bit is rejected and the code ends as all zeros
    wire decided_bit = comparator_i;

    sac_edge_detect u_sclk_edge (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .level_i   (serial_clk_i),
        .rise_o    (sclk_rise),
        .fall_o    (sclk_fall)
    );

    assign status_word = {3'h0, done_flag, twin_latched, channel_pick,
                          input_mode_select, ~(state == st_idle)};

    sac_regs u_regs (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .reg_addr_i  (reg_addr_i),
        .reg_wdata_i (reg_wdata_i),
        .reg_wr_i    (reg_wr_i),
        .reg_rd_i    (reg_rd_i),
        .status_i    (status_word),
        .result_i    (result_hold),
        .twin_o      (twin_cfg),
        .reg_rdata_o (reg_rdata_o)
    );

    // sequencer: addressing on serial clock rises, output on falls
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !active) begin
            // early release lands here too and aborts the conversion
            state                  <= st_idle;
            approximation_register <= 8'h00;
            bit_idx                <= 3'h0;
            addr_sr                <= 2'h0;
            addr_cnt               <= 1'h0;
            input_mode_select      <= 1'b0;
            channel_pick           <= 1'b0;
            twin_latched           <= 1'b0;
            data_bit               <= 1'b0;
            data_oe                <= 1'b0;
        end else begin
            case (state)
                st_idle: begin
                    if (start_seen) begin
                        twin_latched <= twin_cfg;
                        addr_cnt     <= 1'h0;
                        // single channel: fixed polarity, no address word
                        state <= twin_cfg ? st_addr : st_settle;
                    end
                end
                st_addr: begin
                    if (rise_act) begin
                        addr_sr  <= {addr_sr[0], serial_address_in_i};
                        addr_cnt <= addr_cnt + 1'h1;
                    end
                    if (addr_done) begin
                        // first bit in is mode, second is channel pick
                        input_mode_select <= addr_sr[0];
                        channel_pick      <= serial_address_in_i;
                        state             <= st_settle;
                    end
                end
                st_settle: begin
                    if (fall_act) begin
                        data_oe                <= 1'b1;
                        data_bit               <= 1'b0;
                        approximation_register <= `SAC_TRIAL_FIRST;
                        bit_idx                <= `SAC_MSB_IDX;
                        state                  <= st_msb;
                    end
                end
                st_msb: begin
                    // data input is not shifted any more from here on
                    if (fall_act) begin
                        approximation_register[bit_idx] <= decided_bit;
                        data_bit <= decided_bit;
                        if (msb_last) begin
                            // eighth decision closes the conversion
                            bit_idx <= `SAC_LSB_FIRST;
                            state   <= twin_latched ? st_lsb : st_done;
                        end else begin
                            approximation_register[idx_dn] <= 1'b1;
                            bit_idx <= idx_dn;
                        end
                    end
                end
                st_lsb: begin
                    // lsb itself was the last msb-first bit, so echo starts at bit 1
                    if (fall_act) begin
                        data_bit <= approximation_register[bit_idx];
                        bit_idx  <= idx_up;
                        if (lsb_last) begin
                            state <= st_done;
                        end
                    end
                end
                st_done: begin
                    if (fall_act) begin
                        data_bit <= 1'b0;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // result and done flag survive select high so software can read them
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            result_hold <= 8'h00;
            done_flag   <= 1'b0;
        end else if (start_seen) begin
            done_flag <= 1'b0;
        end else if (fall_act && state == st_msb && msb_last) begin
            result_hold <= {approximation_register[7:1], decided_bit};
            done_flag   <= 1'b1;
        end
    end

    // mux steering for the analog front end
    wire pick_eff = twin_latched & channel_pick;
    assign channel_one_positive_o   = pick_eff;
    assign single_ended_o           = twin_latched & input_mode_select;
    assign converting_o             = (state == st_settle) | (state == st_msb);
    assign approximation_register_o = approximation_register;
    assign data_o                   = data_bit;
    assign data_oe_o                = data_oe;

    // helper for counting result decisions
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || state == st_settle) begin
            msb_falls <= 4'h0;
        end else if (fall_act && state == st_msb) begin
            msb_falls <= msb_falls + 4'h1;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    chk_release_clears: assert property (
        select_n_i |=> (state == st_idle) && !data_oe_o && !data_o)
        else $error("select high did not clear and float the output");

    chk_settle_low: assert property (
        (state == st_settle) && fall_act |=> data_oe_o && !data_o && (state == st_msb))
        else $error("settling period did not drive a low");

    chk_no_drive_addr: assert property (
        addressing |-> !data_oe_o)
        else $error("output driven while addressing");

    chk_msb_bit_out: assert property (
        (state == st_msb) && fall_act |=> data_o == $past(comparator_i))
        else $error("decided bit not shown on output");

    chk_eight_periods: assert property (
        (state != st_msb) && $past(state == st_msb) && !$past(select_n_i)
        |-> msb_falls == `SAC_MSB_COUNT)
        else $error("conversion did not take eight periods");

    chk_start_taken: assert property (
        start_seen |=> (state == st_addr) || (state == st_settle))
        else $error("start bit not taken");

    chk_low_ignored: assert property (
        (state == st_idle) && rise_act && !serial_address_in_i |=> state == st_idle)
        else $error("low level before start taken as start");

    chk_input_frozen: assert property (
        (state == st_msb) && rise_act |=> $stable(addr_sr) && $stable(channel_pick))
        else $error("data input shifted during conversion");

    chk_lsb_echo: assert property (
        (state == st_lsb) && fall_act
        |=> data_o == $past(approximation_register[bit_idx]))
        else $error("lsb-first echo bit wrong");

    chk_single_skip: assert property (
        start_seen && !twin_cfg |=> state == st_settle)
        else $error("single-channel variant waited for address");

    chk_quiet_rise: assert property (
        active && !sclk_fall && !(state == st_idle) |=> $stable(data_o))
        else $error("output changed off a falling edge");

    chk_addr_shift: assert property (
        (state == st_addr) && rise_act
        |=> addr_sr[0] == $past(serial_address_in_i))
        else $error("address bit not shifted on serial clock rise");

    chk_assign_order: assert property (
        addr_done
        |=> addr_sr == {input_mode_select, channel_pick})
        else $error("assignment word taken in wrong order");

    chk_addr_to_settle: assert property (
        addr_done
        |=> (state == st_settle) && converting_o && !data_oe_o)
        else $error("conversion did not start after the assignment word");

    chk_first_trial: assert property (
        (state == st_settle) && fall_act
        |=> approximation_register_o == `SAC_TRIAL_FIRST)
        else $error("first trial code not msb alone");

    chk_diff_polarity: assert property (
        twin_latched && !input_mode_select
        |-> !single_ended_o && (channel_one_positive_o == channel_pick))
        else $error("differential polarity not set by channel pick");

    chk_single_ended: assert property (
        twin_latched && input_mode_select
        |-> single_ended_o && (channel_one_positive_o == channel_pick))
        else $error("single-ended channel not set by channel pick");

    chk_fixed_polarity: assert property (
        !twin_latched
        |-> !single_ended_o && !channel_one_positive_o)
        else $error("single-channel variant polarity not fixed");

    chk_result_kept: assert property (
        (state == st_msb) && fall_act && msb_last
        |=> done_flag && (result_hold == approximation_register_o))
        else $error("eighth decision did not close the conversion");

    chk_echo_ends: assert property (
        (state == st_lsb) && fall_act && lsb_last
        |=> (state == st_done) && data_oe_o)
        else $error("lsb-first echo did not end after bit seven");

    chk_tail_low: assert property (
        (state == st_done) && fall_act
        |=> data_oe_o && !data_o)
        else $error("output not low after the echo");

    chk_release_zero: assert property (
        select_n_i
        |=> (approximation_register_o == 8'h00) && !converting_o)
        else $error("select high did not clear the trial code");

    chk_select_gate: assert property (
        select_n_i && (state == st_idle)
        |=> state == st_idle)
        else $error("sequence left idle with select high");

    chk_twin_latch: assert property (
        start_seen
        |=> twin_latched == $past(twin_cfg))
        else $error("variant not latched at the start bit");

    chk_settle_lead: assert property (
        (state == st_settle)
        |-> !data_oe_o && (approximation_register_o == 8'h00))
        else $error("output driven before the settling period");

    cov_twin_done: cover property ((state == st_done) && twin_latched);
    cov_single_done: cover property ((state == st_done) && !twin_latched);
    cov_abort: cover property ((state == st_msb) && select_n_i);
    cov_diff_swap: cover property (converting_o && !single_ended_o && channel_one_positive_o);
    cov_single_chan1: cover property (converting_o && single_ended_o && channel_one_positive_o);

endmodule

`default_nettype wire

// ### test/sac_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none

module sac_ctl_model (
    input  wire logic sys_clk_i,
    input  wire logic data_i,
    input  wire logic data_oe_i,
    input  wire logic converting_i,
    output logic      select_n_o,
    output logic      serial_clk_o,
    output logic      address_o
);
    initial begin
        select_n_o   = 1'b1;
        serial_clk_o = 1'b0;
        address_o    = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // serial clock stands low outside frames; k = 0 is the start bit
    task automatic frame(input logic mode, input logic pick, input int nadr, input int lead,
                         input int n, input int half, output logic [31:0] dq,
                         output logic [31:0] oq, output logic [31:0] cq);
        dq = '0;
        oq = '0;
        cq = '0;
        @(posedge sys_clk_i);
        select_n_o <= 1'b0;
        for (int k = -lead; k < n; k++) begin
            if (k < 0)
                address_o <= 1'b0;
            else if (k < nadr)
                address_o <= (k == 0) ? 1'b1 : ((k == 1) ? mode : pick);
            else
                address_o <= ~address_o;
            tick(half);
            serial_clk_o <= 1'b1;
            #1;
            if (k >= 0) begin
                dq[k] = data_i;
                oq[k] = data_oe_i;
                cq[k] = converting_i;
            end
            tick(half);
            serial_clk_o <= 1'b0;
        end
        tick(half);
        select_n_o <= 1'b1;
    endtask
endmodule

`default_nettype wire

// ### test/serial_sar_adc_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sac_defs.svh"

module serial_sar_adc_control_tb_top;
    import sac_pkg::*;

    logic                   sys_clk;
    logic                   rst;
    logic                   select_n;
    logic                   serial_clk;
    logic                   address_bit;
    logic                   comparator = 1'b0;
    logic                   data;
    logic                   data_oe;
    logic                   chan1_pos;
    logic                   single_ended;
    logic                   converting;
    sac_byte_type           approx;
    sac_byte_type           reg_rdata;
    logic [`SAC_ADDR_W-1:0] reg_addr;
    logic [7:0]             reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    sac_byte_type           ain0;
    sac_byte_type           ain1;
    wire sac_byte_type      pos_in;
    wire sac_byte_type      neg_in;
    logic [7:0]             v;
    logic [31:0]            rnd;
    logic [31:0]            seed = 32'ha3a1;
    int                     errors;
    int                     checks;

    sac_ctl_model ctl (.sys_clk_i(sys_clk), .data_i(data), .data_oe_i(data_oe),
        .converting_i(converting),
        .select_n_o(select_n), .serial_clk_o(serial_clk), .address_o(address_bit));

    sac_top uut (.sys_clk_i(sys_clk), .rst_i(rst), .select_n_i(select_n),
        .serial_clk_i(serial_clk), .serial_address_in_i(address_bit),
        .comparator_i(comparator), .data_o(data), .data_oe_o(data_oe),
        .approximation_register_o(approx), .channel_one_positive_o(chan1_pos),
        .single_ended_o(single_ended), .converting_o(converting), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata));

    // analog side: half-lsb offset keeps comparator ties out of the result
    assign pos_in = chan1_pos ? ain1 : ain0;
    assign neg_in = single_ended ? 8'h00 : (chan1_pos ? ain0 : ain1);
    always @(posedge sys_clk)
        comparator <= ({1'b0, pos_in, 1'b1} > ({1'b0, neg_in, 1'b0} + {1'b0, approx, 1'b0}));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic sac_byte_type exp_res(input logic twin, input logic mode,
                                             input logic pick, input sac_byte_type a0,
                                             input sac_byte_type a1);
        sac_byte_type pos;
        sac_byte_type neg;
        pos = (twin && pick) ? a1 : a0;
        neg = (twin && mode) ? 8'h00 : ((twin && pick) ? a0 : a1);
        return (pos < neg) ? 8'h00 : pos - neg;
    endfunction

    // returns {enable, data} seen at rise k counted from the start bit
    function automatic logic [1:0] exp_bit(input logic twin, input sac_byte_type r, input int k);
        int j;
        j = k - (twin ? 3 : 1);
        if (j < 0)
            return 2'b00;
        if (j == 0 || j > 15)
            return 2'b10;
        if (j <= 8)
            return {1'b1, r[8-j]};
        return {1'b1, r[j-8]};
    endfunction

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic conv(input logic twin, input logic mode, input logic pick, input int lead,
                        input int n);
        logic [31:0] dq;
        logic [31:0] oq;
        logic [31:0] cq;
        logic        x;
        logic [7:0]  r;
        logic [7:0]  s;
        logic [1:0]  e;
        r = exp_res(twin, mode, pick, ain0, ain1);
        ctl.frame(mode, pick, twin ? 3 : 1, lead, n, xs() % 2 ? 4 : 6, dq, oq, cq);
        for (int k = 0; k < n; k++) begin
            e = exp_bit(twin, r, k);
            // converting from settle entry until the eighth decision
            x = (k >= (twin ? 3 : 1)) && (k < (twin ? 11 : 9));
            check("converting_o", {7'h0, x}, {7'h0, cq[k]});
            check("data_oe_o", {7'h0, e[1]}, {7'h0, oq[k]});
            if (e[1])
                check("data_o", {7'h0, e[0]}, {7'h0, dq[k]});
        end
        repeat (3) @(posedge sys_clk);
        #1;
        check("data_oe_o idle", 8'h00, {7'h0, data_oe});
        rd(`SAC_STATUS_OFF, s);
        check("status cleared", 8'h00, {s[7:5], 1'b0, s[3:0]});
        if (n == (twin ? 24 : 10)) begin
            rd(`SAC_RESULT_OFF, v);
            check("result", r, v);
            check("done", 8'h01, {7'h0, s[`SAC_ST_DONE_BIT]});
        end
    endtask

    initial begin
        #300000;
        errors++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ain0 = 8'h00;
        ain1 = 8'h00;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`SAC_CTRL_OFF, v);
        check("ctrl reset", 8'h01, v);
        wr(2'h3, 8'hff);
        wr(`SAC_RESULT_OFF, 8'h5a);
        rd(2'h3, v);
        check("unmapped", 8'h00, v);
        rd(`SAC_RESULT_OFF, v);
        check("result read only", 8'h00, v);
        rd(`SAC_CTRL_OFF, v);
        check("ctrl kept", 8'h01, v);
        $display("test registers done");
        for (int m = 0; m < 8; m++) begin
            ain0 <= (m < 4) ? 8'hc3 : 8'hff;
            ain1 <= (m < 4) ? 8'h3c : 8'h00;
            @(posedge sys_clk);
            conv(1'b1, m[1], m[0], m % 4, 24);
        end
        $display("test channel modes done");
        // an early release in mid-conversion, then a fresh frame must still work
        for (int i = 0; i < 10; i++) begin
            rnd = xs();
            ain0 <= rnd[7:0];
            ain1 <= rnd[15:8];
            @(posedge sys_clk);
            conv(1'b1, rnd[16], rnd[17], int'(rnd[19:18]), (i == 4) ? 8 : 24);
        end
        $display("test random twin done");
        wr(`SAC_CTRL_OFF, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rnd = xs();
            ain0 <= rnd[7:0];
            ain1 <= rnd[15:8];
            @(posedge sys_clk);
            conv(1'b0, rnd[16], rnd[17], int'(rnd[19:18]), 10);
        end
        wr(`SAC_CTRL_OFF, 8'h01);
        $display("test single variant done");
        print_verdict();
    end
endmodule

`default_nettype wire
